//--- core/hpp_pkg.sv
/*
 * Shared constants for the host port and printer pin block: register
 * indices of the printer group, control bit positions, direction patterns.
 * Assumes one system clock and the interface in hpp_if.sv.
 */
package hpp_pkg;
   localparam int        DATA_W        = 8;
   localparam int        ADDR_W        = 3;
   // Printer group register indices
   localparam bit [2:0]  IDX_PDATA     = 3'h0;
   localparam bit [2:0]  IDX_PSTAT     = 3'h1;
   localparam bit [2:0]  IDX_PCTRL     = 3'h2;
   localparam bit [2:0]  IDX_IOSEL     = 3'h3;
   // Control register fields
   localparam int        CTRL_ALF      = 1;
   localparam int        CTRL_IRQ_EN   = 4;
   localparam int        CTRL_DIR      = 5;
   localparam bit [7:0]  CTRL_RESET    = 8'h00;
   // I/O select patterns: input and output
   localparam bit [7:0]  IOSEL_IN      = 8'haa;
   localparam bit [7:0]  IOSEL_OUT     = 8'h55;
   // Status fields
   localparam int        STAT_ACK      = 6;
   localparam int        STAT_BUSY     = 7;
   localparam int        STAT_IRQ      = 2;
   localparam int        STAT_ALF      = 1;
   localparam bit [7:0]  SCRATCH_RESET = 8'h00;
   typedef enum logic [1:0] {HPP_GRP_NONE, HPP_GRP_A, HPP_GRP_B, HPP_GRP_P} hpp_grp_t;
endpackage : hpp_pkg

//--- core/hpp_if.sv
/*
 * Pins between host CPU and device; printer-side pins are ports of the device.
 * Assumes the bench resolves the two-way buses from the enables.
 */
interface hpp_if;
   logic                        chan_first_select_n;
   logic                        chan_second_select_n;
   logic                        printer_group_select_n;
   logic [hpp_pkg::ADDR_W-1:0]  register_index_lines;
   logic                        host_read_strobe_n;
   logic                        host_write_strobe_n;
   logic [hpp_pkg::DATA_W-1:0]  host_data_out;
   logic                        host_data_oe;
   logic [hpp_pkg::DATA_W-1:0]  dev_data_out;
   logic                        dev_data_oe;
   logic [hpp_pkg::DATA_W-1:0]  host_data_in;
   modport dev
   (
      input  chan_first_select_n, chan_second_select_n, printer_group_select_n,
      input  register_index_lines, host_read_strobe_n, host_write_strobe_n, host_data_in,
      output dev_data_out, dev_data_oe
   );
   modport host
   (
      output chan_first_select_n, chan_second_select_n, printer_group_select_n,
      output register_index_lines, host_read_strobe_n, host_write_strobe_n,
      output host_data_out, host_data_oe,
      input  host_data_in
   );
endinterface : hpp_if

//--- core/hpp_dev.sv
/*
 * Device end: select decode, register groups, printer pins, printer irq.
 * Assumes strobes and selects synchronous to clk_sys and host_data_in
 * resolved by the bench from both drivers.
 */
// The address map and strobed register access were chosen for this implementation.
// How it works
// - Low channel-A select opens channel A registers
// - Low channel-B select opens channel B registers
// - Low printer select opens printer registers, data
// - Three index lines pick register in group
// - Strap low: direction from I/O select register
// - Strap high: direction from control bit 5
// - Direction by control bit or AA/55 pattern
// - Data bus driven only while returning reads
// - Data bit zero is register LSB
// - Printer pulls acknowledge low on accepted byte
// - Printer drives busy high when not ready
// - Auto line feed open drain, readable back
// - Latched irq polarity set by parameter
// - Latched until read trailing edge, else follows ack
// - Irq tristated until control bit 4 set
module hpp_dev
   import hpp_pkg::*;
#(
   parameter bit IRQ_ACTIVE_HIGH = 1'b1
)
(
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   hpp_if.dev                         bus,
   input  wire logic                  direction_source_strap,
   input  wire logic                  latch_mode_sel,
   input  wire logic                  printer_ack_n,
   input  wire logic                  printer_busy,
   input  wire logic                  auto_line_feed_n_in,
   input  wire logic [DATA_W-1:0]     parallel_data_in,
   output logic                       auto_line_feed_n_oe,
   output logic [DATA_W-1:0]          parallel_data_out,
   output logic                       parallel_data_oe,
   output logic                       printer_irq,
   output logic                       printer_irq_oe
);
   // ----------------------------------------------------------------
   // Select decode
   // ----------------------------------------------------------------
   function automatic hpp_grp_t grp_of(input logic sa_n, input logic sb_n, input logic sp_n);
      if (!sa_n)
         return HPP_GRP_A;
      else if (!sb_n)
         return HPP_GRP_B;
      else if (!sp_n)
         return HPP_GRP_P;
      else
         return HPP_GRP_NONE;
   endfunction : grp_of

   hpp_grp_t          grp;
   logic              wr;
   logic              rd;
   logic              rd_q;
   logic [DATA_W-1:0] chan_a_q [8];
   logic [DATA_W-1:0] chan_b_q [8];
   logic [DATA_W-1:0] pdata_q;
   logic [DATA_W-1:0] pctrl_q;
   logic [DATA_W-1:0] iosel_q;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] rdata_q;
   logic              oe_q;
   logic              dir_out;
   logic              irq_lat_q;
   logic              ack_q;
   logic              ack_fall;
   logic              rd_end;
   logic              irq_act;
   logic [DATA_W-1:0] stat;
   logic [2:0]        idx;

   assign grp = grp_of(bus.chan_first_select_n, bus.chan_second_select_n, bus.printer_group_select_n);
   assign idx = bus.register_index_lines;
   assign wr  = !bus.host_write_strobe_n && grp != HPP_GRP_NONE;
   assign rd  = !bus.host_read_strobe_n && grp != HPP_GRP_NONE;

   // ----------------------------------------------------------------
   // Direction and status
   // ----------------------------------------------------------------
   assign dir_out = direction_source_strap ? !pctrl_q[CTRL_DIR]
                                           : (iosel_q == IOSEL_OUT);
   assign stat = {printer_busy, printer_ack_n, 3'h0, irq_lat_q, auto_line_feed_n_in, 1'b0};
   assign ack_fall = ack_q && !printer_ack_n;
   assign rd_end   = rd_q && bus.host_read_strobe_n;
   assign irq_act  = latch_mode_sel ? irq_lat_q : !printer_ack_n;

   always_comb
   begin
      rdata_d = 8'h00;
      if (grp == HPP_GRP_A)
         rdata_d = chan_a_q[idx];
      else if (grp == HPP_GRP_B)
         rdata_d = chan_b_q[idx];
      else if (grp == HPP_GRP_P && idx == IDX_PDATA)
         rdata_d = dir_out ? pdata_q : parallel_data_in;
      else if (grp == HPP_GRP_P && idx == IDX_PSTAT)
         rdata_d = stat;
      else if (grp == HPP_GRP_P && idx == IDX_PCTRL)
         rdata_d = pctrl_q;
      else if (grp == HPP_GRP_P && idx == IDX_IOSEL)
         rdata_d = iosel_q;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < 8; i++)
         begin
            chan_a_q[i] <= SCRATCH_RESET;
            chan_b_q[i] <= SCRATCH_RESET;
         end
         pdata_q <= 8'h00;
         pctrl_q <= CTRL_RESET;
         iosel_q <= IOSEL_IN;
      end
      else if (wr)
      begin
         if (grp == HPP_GRP_A)
            chan_a_q[idx] <= bus.host_data_in;
         else if (grp == HPP_GRP_B)
            chan_b_q[idx] <= bus.host_data_in;
         else if (idx == IDX_PDATA)
            pdata_q <= bus.host_data_in;
         else if (idx == IDX_PCTRL)
            pctrl_q <= bus.host_data_in;
         else if (idx == IDX_IOSEL && (bus.host_data_in == IOSEL_IN || bus.host_data_in == IOSEL_OUT))
            iosel_q <= bus.host_data_in;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         rdata_q   <= 8'h00;
         oe_q      <= 1'b0;
         rd_q      <= 1'b0;
         ack_q     <= 1'b1;
         irq_lat_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         oe_q    <= rd;
         rd_q    <= !bus.host_read_strobe_n && grp == HPP_GRP_P;
         ack_q   <= printer_ack_n;
         if (ack_fall)
            irq_lat_q <= 1'b1;
         else if (rd_end)
            irq_lat_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Pin outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         auto_line_feed_n_oe <= 1'b0;
         parallel_data_out   <= 8'h00;
         parallel_data_oe    <= 1'b0;
         printer_irq         <= 1'b0;
         printer_irq_oe      <= 1'b0;
      end
      else
      begin
         auto_line_feed_n_oe <= pctrl_q[CTRL_ALF];
         parallel_data_out   <= pdata_q;
         parallel_data_oe    <= dir_out;
         printer_irq         <= latch_mode_sel ? (irq_act == IRQ_ACTIVE_HIGH) : irq_act;
         printer_irq_oe      <= pctrl_q[CTRL_IRQ_EN];
      end
   end

   assign bus.dev_data_out = rdata_q;
   assign bus.dev_data_oe  = oe_q;
endmodule : hpp_dev

//--- core/hpp_host.sv
/*
 * Host end: turns one-cycle command strobes into pin cycles.
 * Assumes the user strobes are one cycle and never both at once.
 */
module hpp_host
   import hpp_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   hpp_if.host                        bus,
   input  wire logic [1:0]            cmd_group,
   input  wire logic [ADDR_W-1:0]     cmd_index,
   input  wire logic [DATA_W-1:0]     cmd_wdata,
   input  wire logic                  cmd_write,
   input  wire logic                  cmd_read,
   output logic [DATA_W-1:0]          cmd_rdata,
   output logic                       cmd_rvalid
);
   logic [2:0]        sel_n_d;
   logic [2:0]        sel_n_q;
   logic [ADDR_W-1:0] idx_q;
   logic              rd_n_q;
   logic              wr_n_q;
   logic [DATA_W-1:0] wd_q;
   logic              woe_q;
   logic              rd_wait_q;
   logic              active;

   assign active  = cmd_write || cmd_read;
   assign sel_n_d = !active ? 3'h7 : (cmd_group == 2'h1) ? 3'h6 : (cmd_group == 2'h2) ? 3'h5 : 3'h3;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         sel_n_q    <= 3'h7;
         idx_q      <= 3'h0;
         rd_n_q     <= 1'b1;
         wr_n_q     <= 1'b1;
         wd_q       <= 8'h00;
         woe_q      <= 1'b0;
         rd_wait_q  <= 1'b0;
         cmd_rdata  <= 8'h00;
         cmd_rvalid <= 1'b0;
      end
      else
      begin
         sel_n_q    <= sel_n_d;
         idx_q      <= cmd_index;
         rd_n_q     <= !cmd_read;
         wr_n_q     <= !cmd_write;
         wd_q       <= cmd_wdata;
         woe_q      <= cmd_write;
         rd_wait_q  <= !rd_n_q;
         cmd_rvalid <= rd_wait_q;
         if (rd_wait_q)
            cmd_rdata <= bus.host_data_in;
      end
   end

   assign bus.chan_first_select_n    = sel_n_q[0];
   assign bus.chan_second_select_n   = sel_n_q[1];
   assign bus.printer_group_select_n = sel_n_q[2];
   assign bus.register_index_lines   = idx_q;
   assign bus.host_read_strobe_n     = rd_n_q;
   assign bus.host_write_strobe_n    = wr_n_q;
   assign bus.host_data_out          = wd_q;
   assign bus.host_data_oe           = woe_q;
endmodule : hpp_host

//--- sim/hpp_monitor.sv
/*
 * Checker on the pins between the host end and the device end.
 * Assumes one clock, reset low, and instantiation beside the interface.
 */
module hpp_monitor
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic chan_first_select_n,
   input wire logic chan_second_select_n,
   input wire logic printer_group_select_n,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic host_data_oe,
   input wire logic dev_data_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   wire any_sel = !(chan_first_select_n && chan_second_select_n && printer_group_select_n);
   sequence s_rd_cycle;
      !host_read_strobe_n && any_sel;
   endsequence
   sequence s_idle;
      !any_sel;
   endsequence
   a_one_select: assert property ($onehot0({~chan_first_select_n, ~chan_second_select_n, ~printer_group_select_n}))
      else $error("more than one group select low");
   a_read_drives: assert property (s_rd_cycle |=> dev_data_oe)
      else $error("read cycle without data drive");
   a_drive_cause: assert property (dev_data_oe |-> $past(!host_read_strobe_n && any_sel))
      else $error("data driven without a selected read");
   a_no_clash: assert property (!(host_data_oe && dev_data_oe))
      else $error("both ends drive the data bus");
   a_host_writes: assert property (host_data_oe |-> !host_write_strobe_n && host_read_strobe_n)
      else $error("host drives data outside a write");
   a_strobe_apart: assert property (!(!host_read_strobe_n && !host_write_strobe_n))
      else $error("both strobes low");
   a_sel_strobe: assert property (any_sel |-> !host_read_strobe_n || !host_write_strobe_n)
      else $error("select low without a strobe");
   a_quiet_idle: assert property (s_idle[*2] |=> !dev_data_oe)
      else $error("bus driven with no select");
endmodule : hpp_monitor

//--- sim/tb.sv
/*
 * Testbench: host end and device end joined by the interface.
 * Assumes the printer side pins are modelled here: auto line feed pulled up, data pins driven with 96 when released.
 */
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import hpp_pkg::*;
   logic            clk_sys = 1'b0;
   logic            nrst = 1'b0;
   logic            strap = 1'b0;
   logic            latch_sel = 1'b0;
   logic            ack_n = 1'b1;
   logic            busy = 1'b0;
   logic [7:0]      pd_drv = 8'h96;
   logic [7:0]      pat = 8'h00;
   logic [1:0]      cmd_group = 2'h0;
   logic [2:0]      cmd_index = 3'h0;
   logic [7:0]      cmd_wdata = 8'h00;
   logic            cmd_write = 1'b0;
   logic            cmd_read = 1'b0;
   logic [7:0]      cmd_rdata, pd_out;
   logic            cmd_rvalid, alf_oe, pd_oe, irq, irq_oe;
   wire logic       alf_in = alf_oe ? 1'b0 : 1'b1;
   wire logic [7:0] pd_in = pd_oe ? pd_out : pd_drv;
   int              n_fail = 0;
   int              check_count = 0;
   hpp_if u_if();
   // Released bus shows a changing pattern
   assign u_if.host_data_in = u_if.dev_data_oe ? u_if.dev_data_out : u_if.host_data_oe ? u_if.host_data_out : pat;
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) pat <= pat + 8'h01;
   hpp_host u_hpp_host (.clk_sys(clk_sys), .nrst(nrst), .bus(u_if.host), .cmd_group(cmd_group),
      .cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .cmd_write(cmd_write), .cmd_read(cmd_read),
      .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));
   hpp_dev #(.IRQ_ACTIVE_HIGH(1'b1)) u_hpp_dev (.clk_sys(clk_sys), .nrst(nrst), .bus(u_if.dev),
      .direction_source_strap(strap), .latch_mode_sel(latch_sel), .printer_ack_n(ack_n),
      .printer_busy(busy), .auto_line_feed_n_in(alf_in), .parallel_data_in(pd_in),
      .auto_line_feed_n_oe(alf_oe), .parallel_data_out(pd_out), .parallel_data_oe(pd_oe),
      .printer_irq(irq), .printer_irq_oe(irq_oe));
   hpp_monitor u_hpp_monitor (.clk_sys(clk_sys), .nrst(nrst), .chan_first_select_n(u_if.chan_first_select_n),
      .chan_second_select_n(u_if.chan_second_select_n), .printer_group_select_n(u_if.printer_group_select_n),
      .host_read_strobe_n(u_if.host_read_strobe_n), .host_write_strobe_n(u_if.host_write_strobe_n),
      .host_data_oe(u_if.host_data_oe), .dev_data_oe(u_if.dev_data_oe));
   // ----
   // Access tasks
   // ----
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : idle
   task automatic wr(input logic [1:0] g, input logic [2:0] i, input logic [7:0] d);
      @(posedge clk_sys);
      cmd_group <= g;
      cmd_index <= i;
      cmd_wdata <= d;
      cmd_write <= 1'b1;
      @(posedge clk_sys);
      cmd_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] g, input logic [2:0] i, input logic [7:0] exp, input logic [7:0] m,
                     input string name);
      int k;
      @(posedge clk_sys);
      cmd_group <= g;
      cmd_index <= i;
      cmd_read <= 1'b1;
      @(posedge clk_sys);
      cmd_read <= 1'b0;
      for (k = 0; k < 8 && cmd_rvalid !== 1'b1; k++)
         @(negedge clk_sys);
      if (cmd_rvalid !== 1'b1)
      begin
         $display("unexpected read answer: expected 1 seen %b", cmd_rvalid);
         n_fail++;
         give_verdict();
      end
      else
         chk(name, exp & m, cmd_rdata & m);
   endtask : rd
   // ----
   // Main sequence
   // ----
   initial
   begin
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      wr(2'h1, 3'h5, 8'h3c);
      wr(2'h2, 3'h5, 8'hc3);
      wr(2'h1, 3'h6, 8'h01);
      rd(2'h1, 3'h5, 8'h3c, 8'hff, "group a reg5");
      rd(2'h2, 3'h5, 8'hc3, 8'hff, "group b reg5");
      rd(2'h1, 3'h6, 8'h01, 8'hff, "group a lsb");
      rd(2'h2, 3'h6, 8'h00, 8'hff, "group b reg6");
      $display("test groups done");
      chk("pd oe after reset", 1'b0, pd_oe);
      wr(2'h3, IDX_PDATA, 8'h81);
      wr(2'h3, IDX_IOSEL, IOSEL_OUT);
      idle(4);
      chk("pd oe at 55", 1'b1, pd_oe);
      chk("pd out", 8'h81, pd_out);
      wr(2'h3, IDX_IOSEL, 8'h12);
      idle(4);
      chk("pd oe bad pattern", 1'b1, pd_oe);
      wr(2'h3, IDX_IOSEL, IOSEL_IN);
      idle(4);
      chk("pd oe at aa", 1'b0, pd_oe);
      rd(2'h3, IDX_PDATA, 8'h96, 8'hff, "pd input");
      @(posedge clk_sys) strap <= 1'b1;
      wr(2'h3, IDX_PCTRL, 8'h00);
      idle(4);
      chk("pd oe ctrl out", 1'b1, pd_oe);
      wr(2'h3, IDX_PCTRL, 8'h20);
      idle(4);
      chk("pd oe ctrl in", 1'b0, pd_oe);
      $display("test direction done");
      @(posedge clk_sys) busy <= 1'b1;
      rd(2'h3, IDX_PSTAT, 8'hc0, 8'hc0, "status busy");
      @(posedge clk_sys) busy <= 1'b0;
      @(posedge clk_sys) ack_n <= 1'b0;
      rd(2'h3, IDX_PSTAT, 8'h00, 8'hc0, "status ack");
      chk("irq oe off", 1'b0, irq_oe);
      @(posedge clk_sys) ack_n <= 1'b1;
      rd(2'h3, IDX_PSTAT, 8'h02, 8'h02, "alf released");
      wr(2'h3, IDX_PCTRL, 8'h02);
      idle(4);
      chk("alf drive", 1'b1, alf_oe);
      rd(2'h3, IDX_PSTAT, 8'h00, 8'h02, "alf readback");
      $display("test status done");
      wr(2'h3, IDX_PCTRL, 8'h10);
      idle(4);
      chk("irq oe on", 1'b1, irq_oe);
      chk("irq idle", 1'b0, irq);
      @(posedge clk_sys) ack_n <= 1'b0;
      idle(4);
      chk("irq follows", 1'b1, irq);
      @(posedge clk_sys) ack_n <= 1'b1;
      idle(4);
      chk("irq follows off", 1'b0, irq);
      @(posedge clk_sys) latch_sel <= 1'b1;
      rd(2'h3, IDX_PSTAT, 8'h04, 8'h04, "stale irq latch");
      idle(4);
      chk("irq before ack", 1'b0, irq);
      @(posedge clk_sys) ack_n <= 1'b0;
      @(posedge clk_sys) ack_n <= 1'b1;
      idle(4);
      chk("irq latched", 1'b1, irq);
      rd(2'h3, IDX_PSTAT, 8'h46, 8'hff, "status irq");
      idle(4);
      chk("irq cleared", 1'b0, irq);
      $display("test irq done");
      give_verdict();
   end
endmodule : tb
